/* File: hw/bmd_pkg.sv */
/*
 Shared constants and types of the block move and opcode decode unit.
 Assumes a 32-bit APB master and a byte-wide on-chip memory port.
*/
`default_nettype none
package bmd_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_SRC    = 8'h04;
  localparam logic [7:0] OFS_DST    = 8'h08;
  localparam logic [7:0] OFS_COUNT  = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_CCR    = 8'h14;
  localparam logic [7:0] OFS_OPA    = 8'h18;
  localparam logic [7:0] OFS_OPB    = 8'h1C;
  localparam logic [7:0] OFS_ALUOP  = 8'h20;
  localparam logic [7:0] OFS_OPCODE = 8'h24;
  localparam logic [7:0] OFS_DECODE = 8'h28;
  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int CTRL_START = 0;
  localparam int CTRL_WORD  = 1;
  localparam int CCR_C = 0;
  localparam int CCR_V = 1;
  localparam int CCR_Z = 2;
  localparam int CCR_N = 3;
  localparam int CCR_H = 5;
  localparam logic [7:0]  CCR_RESET = 8'h80;
  localparam logic [15:0] PTR_RESET = 16'h0000;
  // ----------------------------------------
  // Timing in states (one state is one clock)
  // ----------------------------------------
  localparam logic [3:0] HEAD_STATES = 4'h8;
  localparam logic [3:0] BYTE_STATES = 4'h4;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [3:0] {
    ALU_ADDW = 4'h0, ALU_SUBW = 4'h1, ALU_ADDL = 4'h2, ALU_SUBL = 4'h3,
    ALU_ADDX = 4'h4, ALU_SUBX = 4'h5, ALU_DAA  = 4'h6, ALU_DIVU = 4'h7,
    ALU_DIVS = 4'h8
  } bmd_alu_op_t;
  typedef enum logic [3:0] {
    DEC_UNDEF = 4'h0, DEC_BRANCH = 4'h1, DEC_INC = 4'h2, DEC_ADD = 4'h3,
    DEC_DEC   = 4'h4, DEC_SUB    = 4'h5, DEC_DAA = 4'h6, DEC_MOV = 4'h7,
    DEC_DAS   = 4'h8, DEC_CMP    = 4'h9, DEC_BLKB = 4'hA, DEC_BLKW = 4'hB
  } bmd_class_t;
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } bmd_mem_req_t;
endpackage
`default_nettype wire

/* File: hw/bmd_core.sv */
/*
 Block move engine, flag evaluation unit and first-level opcode decoder,
 plus the byte FIFO in the move's data path.
 Assumes an APB master on ref_clk and a memory that acknowledges each access.
*/
`default_nettype none
// ----------------------------------------
// Byte FIFO
// ----------------------------------------
module bmd_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  wrPtr_q;
  logic [AW:0]  rdPtr_q;
  logic         push;
  logic         pop;

  // Full and empty from pointer wrap bits
  assign inReady  = (wrPtr_q ^ rdPtr_q) != {1'b1, {AW{1'b0}}};
  assign outValid = wrPtr_q != rdPtr_q;
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;
  assign outData  = mem[rdPtr_q[AW-1:0]];

  // Storage
  always_ff @(posedge ref_clk)
  begin
    if (push)
      mem[wrPtr_q[AW-1:0]] <= inData;
  end

  // Pointers
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end
    else
    begin
      if (push)
        wrPtr_q <= wrPtr_q + 1'b1;
      if (pop)
        rdPtr_q <= rdPtr_q + 1'b1;
    end
  end
endmodule

// How it works
// (RULE_01) While the count is nonzero each byte at the source pointer goes to the destination, both pointers rise, count falls.
// (RULE_02) A zero count moves nothing and finishes, and the move never touches the condition flags.
// (RULE_03) With memory answering at once the move takes eight states plus four per byte.
// (RULE_04) Word arithmetic sets half-carry on carry or borrow out of bit 11, else clears it.
// (RULE_05) Longword arithmetic sets half-carry on carry or borrow out of bit 27, else clears it.
// (RULE_06) Add and subtract with carry keep zero on a zero result and clear it otherwise.
// (RULE_07) Decimal adjust sets carry when the adjustment carries, else keeps it.
// (RULE_08) Accesses that wait on a slow peripheral stretch the move by the wait.
// (RULE_09) Unsigned divide sets sign when the divisor is negative, else clears it.
// (RULE_10) Divides set zero when the divisor is zero, else clear it.
// (RULE_11) Signed divide sets sign when the quotient is negative, else clears it.
// (RULE_12) Some first bytes pick one of two instructions by the top bit of the second byte's upper nibble.
// (RULE_13) First bytes with upper nibble 4 are short branches, the lower nibble giving the condition.
module bmd_core (
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  output bmd_pkg::bmd_mem_req_t      memReq,
  input  wire logic                  memAck,
  input  wire logic [7:0]            memRdata,
  output logic                       busy
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_HEAD = 3'b001, ST_RDREQ = 3'b010,
    ST_RDWAIT = 3'b011, ST_WRREQ = 3'b100, ST_WRWAIT = 3'b101
  } bmd_state_t;

  bmd_state_t  state_q;
  logic [15:0] srcPtr_q;
  logic [15:0] dstPtr_q;
  logic [15:0] count_q;
  logic        wordForm_q;
  logic [3:0]  headCnt_q;
  logic [15:0] stateCnt_q;
  logic [7:0]  ccr_q;
  logic [31:0] opA_q;
  logic [31:0] opB_q;
  logic [15:0] opcode_q;
  logic        ready_q;
  logic [31:0] rdata_q;
  logic        err_q;
  logic        wrEn;
  logic        rdEn;
  logic        mapped;
  logic        start;
  logic        fifoInReady;
  logic        fifoOutValid;
  logic [7:0]  fifoOutData;
  logic        pushByte;
  logic        popByte;
  logic [15:0] countNext;
  logic [7:0]  ccrAlu;
  bmd_pkg::bmd_class_t decClass;
  logic [3:0]  decCond;

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // Answer in the second access cycle
  assign wrEn    = psel & penable & ready_q & pwrite;
  assign rdEn    = psel & penable & ~ready_q & ~pwrite;
  assign pready  = ready_q;
  assign prdata  = rdata_q;
  assign pslverr = err_q;
  assign mapped  = (paddr[1:0] == 2'b00) && (paddr <= bmd_pkg::OFS_DECODE);
  assign start   = wrEn && mapped && paddr == bmd_pkg::OFS_CTRL && pwdata[bmd_pkg::CTRL_START];

  // Ready and error
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ready_q <= 1'b0;
      err_q   <= 1'b0;
    end
    else
    begin
      ready_q <= psel & penable & ~ready_q;
      err_q   <= psel & penable & ~ready_q & ~mapped;
    end
  end

  // Read data capture
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_q <= '0;
    else if (rdEn)
    begin
      case (paddr)
        bmd_pkg::OFS_CTRL:   rdata_q <= {30'h0, wordForm_q, 1'b0};
        bmd_pkg::OFS_SRC:    rdata_q <= {16'h0, srcPtr_q};
        bmd_pkg::OFS_DST:    rdata_q <= {16'h0, dstPtr_q};
        bmd_pkg::OFS_COUNT:  rdata_q <= {16'h0, count_q};
        bmd_pkg::OFS_STATUS: rdata_q <= {stateCnt_q, 15'h0, busy};
        bmd_pkg::OFS_CCR:    rdata_q <= {24'h0, ccr_q};
        bmd_pkg::OFS_OPA:    rdata_q <= opA_q;
        bmd_pkg::OFS_OPB:    rdata_q <= opB_q;
        bmd_pkg::OFS_OPCODE: rdata_q <= {16'h0, opcode_q};
        bmd_pkg::OFS_DECODE: rdata_q <= {24'h0, decCond, decClass};
        default:             rdata_q <= '0;
      endcase
    end
  end

  // Operand and opcode registers
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      opA_q    <= '0;
      opB_q    <= '0;
      opcode_q <= '0;
    end
    else if (wrEn)
    begin
      if (paddr == bmd_pkg::OFS_OPA)
        opA_q <= pwdata;
      if (paddr == bmd_pkg::OFS_OPB)
        opB_q <= pwdata;
      if (paddr == bmd_pkg::OFS_OPCODE)
        opcode_q <= pwdata[15:0];
    end
  end

  // ----------------------------------------
  // Flag evaluation
  // ----------------------------------------
  // Borrow or carry out of the low k bits
  function automatic logic carryAt(input logic [31:0] a, input logic [31:0] b, input int k, input logic sub);
    logic [32:0] s;
    logic [31:0] m;
    s = '0;
    m = (32'h1 << k) - 32'h1;
    if (sub)
      s = {1'b0, a & m} - {1'b0, b & m};
    else
      s = {1'b0, a & m} + {1'b0, b & m};
    carryAt = sub ? s[32] : s[k];
  endfunction

  // Magnitude of a signed value
  function automatic logic [31:0] absVal(input logic [31:0] v);
    absVal = v[31] ? (~v + 32'h1) : v;
  endfunction

  // New flags for the chosen operation
  always_comb
  begin
    logic [8:0]  x;
    logic [31:0] dvs;
    x      = '0;
    dvs    = {{16{opB_q[15]}}, opB_q[15:0]};
    ccrAlu = ccr_q;
    case (pwdata[3:0])
      bmd_pkg::ALU_ADDW, bmd_pkg::ALU_SUBW:
        ccrAlu[bmd_pkg::CCR_H] = carryAt(opA_q, opB_q, 12, pwdata[0]); // RULE_04
      bmd_pkg::ALU_ADDL, bmd_pkg::ALU_SUBL:
        ccrAlu[bmd_pkg::CCR_H] = carryAt(opA_q, opB_q, 28, pwdata[0]); // RULE_05
      bmd_pkg::ALU_ADDX, bmd_pkg::ALU_SUBX:
      begin
        if (pwdata[0])
          x = {1'b0, opA_q[7:0]} - {1'b0, opB_q[7:0]} - {8'h0, ccr_q[bmd_pkg::CCR_C]};
        else
          x = {1'b0, opA_q[7:0]} + {1'b0, opB_q[7:0]} + {8'h0, ccr_q[bmd_pkg::CCR_C]};
        ccrAlu[bmd_pkg::CCR_C] = x[8];
        ccrAlu[bmd_pkg::CCR_N] = x[7];
        if (x[7:0] != 8'h00)
          ccrAlu[bmd_pkg::CCR_Z] = 1'b0; // RULE_06
      end
      bmd_pkg::ALU_DAA:
        if (ccr_q[bmd_pkg::CCR_C] || opA_q[7:0] > 8'h99)
          ccrAlu[bmd_pkg::CCR_C] = 1'b1; // RULE_07
      bmd_pkg::ALU_DIVU:
      begin
        ccrAlu[bmd_pkg::CCR_N] = opB_q[15]; // RULE_09
        ccrAlu[bmd_pkg::CCR_Z] = opB_q[15:0] == 16'h0000; // RULE_10
      end
      bmd_pkg::ALU_DIVS:
      begin
        ccrAlu[bmd_pkg::CCR_N] = (opA_q[31] ^ opB_q[15]) && (opB_q[15:0] != 16'h0000)
                                 && (absVal(opA_q) >= absVal(dvs)); // RULE_11
        ccrAlu[bmd_pkg::CCR_Z] = opB_q[15:0] == 16'h0000; // RULE_10
      end
      default: ccrAlu = ccr_q;
    endcase
  end

  // Condition flags: software or flag unit only
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      ccr_q <= bmd_pkg::CCR_RESET;
    else if (wrEn && paddr == bmd_pkg::OFS_CCR)
      ccr_q <= pwdata[7:0];
    else if (wrEn && paddr == bmd_pkg::OFS_ALUOP)
      ccr_q <= ccrAlu;
  end

  // ----------------------------------------
  // Opcode decode
  // ----------------------------------------
  // Class from first byte, second byte where needed
  always_comb
  begin
    logic bhTop;
    bhTop    = opcode_q[7];
    decCond  = 4'h0;
    decClass = bmd_pkg::DEC_UNDEF;
    case (opcode_q[15:8])
      8'h0A: decClass = bhTop ? bmd_pkg::DEC_ADD : bmd_pkg::DEC_INC; // RULE_12
      8'h1A: decClass = bhTop ? bmd_pkg::DEC_SUB : bmd_pkg::DEC_DEC; // RULE_12
      8'h0F: decClass = bhTop ? bmd_pkg::DEC_MOV : bmd_pkg::DEC_DAA; // RULE_12
      8'h1F: decClass = bhTop ? bmd_pkg::DEC_CMP : bmd_pkg::DEC_DAS; // RULE_12
      8'h7B: decClass = bhTop ? bmd_pkg::DEC_BLKW : bmd_pkg::DEC_BLKB; // RULE_12
      default:
        if (opcode_q[15:12] == 4'h4)
        begin
          decClass = bmd_pkg::DEC_BRANCH; // RULE_13
          decCond  = opcode_q[11:8]; // RULE_13
        end
    endcase
  end

  // ----------------------------------------
  // Block move engine
  // ----------------------------------------
  assign busy     = state_q != ST_IDLE;
  assign pushByte = state_q == ST_RDWAIT && memAck;
  assign popByte  = state_q == ST_WRWAIT && memAck;
  assign countNext = wordForm_q ? count_q - 16'h1 : {count_q[15:8], count_q[7:0] - 8'h1};

  // Memory request from state and pointers
  always_comb
  begin
    memReq.valid = state_q inside {ST_RDREQ, ST_RDWAIT, ST_WRREQ, ST_WRWAIT};
    memReq.write = state_q inside {ST_WRREQ, ST_WRWAIT};
    memReq.addr  = memReq.write ? dstPtr_q : srcPtr_q;
    memReq.wdata = fifoOutData;
  end

  // Sequencer; acks that come late stretch the move
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q   <= ST_IDLE;
      headCnt_q <= '0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
          if (start)
          begin
            state_q   <= ST_HEAD;
            headCnt_q <= 4'h1;
          end
        ST_HEAD:
          if (headCnt_q == bmd_pkg::HEAD_STATES)
          begin
            // Zero count ends after the head
            if ((wordForm_q ? count_q : {8'h00, count_q[7:0]}) == 16'h0000)
              state_q <= ST_IDLE; // RULE_02
            else
              state_q <= ST_RDREQ; // RULE_01
          end
          else
            headCnt_q <= headCnt_q + 4'h1; // RULE_03
        ST_RDREQ:
          if (fifoInReady)
            state_q <= ST_RDWAIT;
        ST_RDWAIT:
          if (memAck)
            state_q <= ST_WRREQ; // RULE_08
        ST_WRREQ:
          if (fifoOutValid)
            state_q <= ST_WRWAIT;
        ST_WRWAIT:
          if (memAck)
          begin
            if ((wordForm_q ? countNext : {8'h00, countNext[7:0]}) == 16'h0000)
              state_q <= ST_IDLE; // RULE_01
            else
              state_q <= ST_RDREQ; // RULE_03
          end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Pointers, count and form
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      srcPtr_q   <= bmd_pkg::PTR_RESET;
      dstPtr_q   <= bmd_pkg::PTR_RESET;
      count_q    <= '0;
      wordForm_q <= 1'b0;
    end
    else if (busy)
    begin
      if (pushByte)
        srcPtr_q <= srcPtr_q + 16'h1; // RULE_01
      if (popByte)
      begin
        dstPtr_q <= dstPtr_q + 16'h1; // RULE_01
        count_q  <= countNext; // RULE_01
      end
    end
    else if (wrEn)
    begin
      case (paddr)
        bmd_pkg::OFS_CTRL:  wordForm_q <= pwdata[bmd_pkg::CTRL_WORD];
        bmd_pkg::OFS_SRC:   srcPtr_q   <= pwdata[15:0];
        bmd_pkg::OFS_DST:   dstPtr_q   <= pwdata[15:0];
        bmd_pkg::OFS_COUNT: count_q    <= pwdata[15:0];
        default:            count_q    <= count_q;
      endcase
    end
  end

  // States spent by the last move
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      stateCnt_q <= '0;
    else if (start && !busy)
      stateCnt_q <= 16'h1;
    else if (busy
             && !(state_q == ST_WRWAIT && memAck && (wordForm_q ? countNext : {8'h00, countNext[7:0]}) == 16'h0)
             && !(state_q == ST_HEAD && headCnt_q == bmd_pkg::HEAD_STATES
                  && (wordForm_q ? count_q : {8'h00, count_q[7:0]}) == 16'h0))
      stateCnt_q <= stateCnt_q + 16'h1; // RULE_03
  end

  // Byte buffer between read and write
  bmd_fifo #(
    .W (8),
    .D (4)
  ) u_fifo (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .inValid  (pushByte),
    .inReady  (fifoInReady),
    .inData   (memRdata),
    .outValid (fifoOutValid),
    .outReady (popByte),
    .outData  (fifoOutData)
  );
endmodule
`default_nettype wire

/* File: tb/bmd_core_asserts.sv */
/*
 Checker of bmd_core port behaviour, bound onto the core.
 Assumes a memory that never acks in a request's first cycle.
*/
`default_nettype none
module bmd_core_asserts (
  input wire logic                  ref_clk,
  input wire logic                  rst_n,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [7:0]            paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire bmd_pkg::bmd_mem_req_t memReq,
  input wire logic                  memAck,
  input wire logic [7:0]            memRdata,
  input wire logic                  busy
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ----
  // Memory steps
  // ----
  sequence rdAck_s;
    memReq.valid && !memReq.write && memAck && $past(memReq.valid);
  endsequence
  sequence wrAck_s;
    memReq.valid && memReq.write && memAck && $past(memReq.valid);
  endsequence
  // Bus answer
  pready_pulse_a: assert property (pready |=> !pready) else $error("pready held too long");
  apb_wait_a: assert property (psel && penable && !pready |=> pready) else $error("late bus answer");
  err_pair_a: assert property (pslverr |-> pready) else $error("error without ready");
  unmapped_err_a: assert property (psel && penable && pready && paddr > 8'h28 |-> pslverr)
    else $error("unmapped access not refused");
  // Move engine
  req_hold_a: assert property (memReq.valid && !memAck |=> $stable(memReq))
    else $error("request changed before ack");
  idle_quiet_a: assert property (!busy |-> !memReq.valid) else $error("access while idle");
  head_len_a: assert property ($rose(busy) |-> (!memReq.valid) [*8] ##1 (memReq.valid || !busy))
    else $error("head length wrong");
  rd_then_wr_a: assert property (rdAck_s |=> memReq.valid && memReq.write && memReq.wdata == $past(memRdata))
    else $error("read not followed by write of byte");
  wr_then_next_a: assert property (wrAck_s |=> (memReq.valid && !memReq.write) || !busy)
    else $error("gap after write");
endmodule
bind bmd_core bmd_core_asserts u_bmd_core_asserts (
  .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .memReq(memReq), .memAck(memAck), .memRdata(memRdata), .busy(busy));
`default_nettype wire

/* File: tb/bmd_mem_model.sv */
/*
 Byte memory answering the move engine, with a settable wait.
 Assumes requests held until acked.
*/
`default_nettype none
module bmd_mem_model (
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  input  wire bmd_pkg::bmd_mem_req_t memReq,
  input  wire logic [1:0]            waitCyc,
  output logic                       memAck,
  output logic [7:0]                 memRdata
);
  logic [7:0] mem [0:65535];
  int         cnt;
  // Ack after the wait; data toggles when not valid
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      memAck <= 1'h0;
      cnt <= 0;
      memRdata <= 8'h00;
    end
    else if (memReq.valid && !memAck && cnt >= waitCyc)
    begin
      memAck <= 1'h1;
      cnt <= 0;
      if (memReq.write)
        mem[memReq.addr] <= memReq.wdata;
      memRdata <= memReq.write ? ~memRdata : mem[memReq.addr];
    end
    else
    begin
      memAck <= 1'h0;
      memRdata <= ~memRdata;
      cnt <= (memReq.valid && !memAck) ? cnt + 1 : 0;
    end
  end
endmodule
`default_nettype wire

/* File: tb/block_move_and_opcode_decode_bench.sv */
/*
 Self-checking bench of bmd_core over APB.
 Assumes bmd_pkg, bmd_core and bmd_mem_model compiled first.
*/
`default_nettype none
module block_move_and_opcode_decode_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  ref_clk = 1'h0;
  logic                  rst_n = 1'h0;
  logic                  psel = 1'h0;
  logic                  penable = 1'h0;
  logic                  pwrite = 1'h0;
  logic [7:0]            paddr = 8'h00;
  logic [31:0]           pwdata = 32'h0;
  logic [31:0]           prdata, rdv, a, b;
  logic                  pready, pslverr, memAck, busy, errSeen;
  logic [7:0]            memRdata, f;
  logic [3:0]            op;
  logic [1:0]            waitCyc = 2'h0;
  bmd_pkg::bmd_mem_req_t memReq;
  logic [7:0]            fb [5] = '{8'h0A, 8'h1A, 8'h0F, 8'h1F, 8'h7B};
  logic [3:0]            cl [5] = '{4'h2, 4'h4, 4'h6, 4'h8, 4'hA};
  int                    fails = 0;
  int                    totalChecks = 0;
  int                    cyc = 0;
  bmd_core u_bmd_core (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .memReq(memReq), .memAck(memAck), .memRdata(memRdata), .busy(busy));
  bmd_mem_model u_bmd_mem_model (.ref_clk(ref_clk), .rst_n(rst_n), .memReq(memReq),
    .waitCyc(waitCyc), .memAck(memAck), .memRdata(memRdata));
  // Clock and hang limit
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      fails++;
      finish_test();
    end
  end
  // ----
  // Shared tasks
  // ----
  task automatic finish_test();
    $display("checks %0d mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    totalChecks++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (n >= 50)
      chk("pready", 32'h1, 32'h0);
    rdv = prdata;
    errSeen = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge ref_clk);
  endtask
  // Flags after one arithmetic step; signed divide from the true quotient
  function automatic logic [7:0] expCcr(input logic [3:0] o, input logic [31:0] x,
                                        input logic [31:0] y, input logic [7:0] c);
    logic [28:0] t;
    logic [7:0]  e;
    int          q;
    e = c;
    t = 29'h0;
    q = 0;
    case (o)
      4'h0: t = x[11:0] + y[11:0];
      4'h1: t = {16'h0, x[11:0] < y[11:0], 12'h0};
      4'h2: t = x[27:0] + y[27:0];
      4'h3: t = {x[27:0] < y[27:0], 28'h0};
      4'h4, 4'h5:
      begin
        t = (o == 4'h4) ? x[7:0] + y[7:0] + c[0] : x[7:0] - y[7:0] - c[0];
        e[0] = t[8];
        e[3] = t[7];
        if (t[7:0] != 8'h00)
          e[2] = 1'h0;
      end
      4'h6: e[0] = c[0] | (x[7:0] > 8'h99);
      4'h7:
      begin
        e[3] = y[15];
        e[2] = y[15:0] == 16'h0;
      end
      4'h8:
      begin
        if (y[15:0] != 16'h0)
          q = $signed(x) / $signed(y[15:0]);
        e[3] = q < 0;
        e[2] = y[15:0] == 16'h0;
      end
      default: e = c;
    endcase
    if (o < 4'h2)
      e[5] = t[12];
    if (o == 4'h2 || o == 4'h3)
      e[5] = t[28];
    return e;
  endfunction
  // One move with its results
  task automatic mv(input logic wd, input logic [15:0] c, input logic [1:0] w);
    logic [15:0] s, d, n;
    s = 16'($urandom) & 16'h7FFF;
    d = s + 16'h0100;
    n = wd ? c : {8'h00, c[7:0]};
    for (int k = 0; k < 8; k++)
    begin
      u_bmd_mem_model.mem[16'(s + k)] = 8'($urandom);
      u_bmd_mem_model.mem[16'(d + k)] = ~u_bmd_mem_model.mem[16'(s + k)];
    end
    waitCyc <= w;
    apb(1'h0, 8'h14, 32'h0);
    f = rdv[7:0];
    apb(1'h1, 8'h04, {16'h0, s});
    apb(1'h1, 8'h08, {16'h0, d});
    apb(1'h1, 8'h0C, {16'h0, c});
    apb(1'h1, 8'h00, {30'h0, wd, 1'h1});
    @(posedge ref_clk);
    for (int k = 0; k < 400 && busy !== 1'h0; k++)
      @(posedge ref_clk);
    for (int k = 0; k <= n; k++)
      chk("copy", {24'h0, u_bmd_mem_model.mem[16'(s + k)] ^ ((k == n) ? 8'hFF : 8'h00)},
          {24'h0, u_bmd_mem_model.mem[16'(d + k)]});
    apb(1'h0, 8'h04, 32'h0);
    chk("src", {16'h0, s + n}, rdv);
    apb(1'h0, 8'h08, 32'h0);
    chk("dst", {16'h0, d + n}, rdv);
    apb(1'h0, 8'h0C, 32'h0);
    chk("count", wd ? 32'h0 : {16'h0, c[15:8], 8'h00}, rdv);
    apb(1'h0, 8'h10, 32'h0);
    chk("states", {16'(8 + n * (4 + 2 * w)), 16'h0}, rdv & 32'hFFFF_0001);
    apb(1'h0, 8'h14, 32'h0);
    chk("flags", {24'h0, f}, rdv);
  endtask
  // ----
  // Main sequence
  // ----
  initial
  begin
    void'($urandom(3));
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'h1;
    @(posedge ref_clk);
    apb(1'h0, 8'h14, 32'h0);
    chk("ccr reset", 32'h80, rdv);
    apb(1'h0, 8'h2C, 32'h0);
    chk("unmapped", 32'h1, {31'h0, errSeen});
    mv(1'h0, 16'h0100, 2'h0);
    mv(1'h1, 16'h0000, 2'h1);
    mv(1'h0, 16'hA503, 2'h0);
    repeat (6) mv(1'($urandom), 16'($urandom % 6), 2'($urandom % 3));
    for (int i = 0; i < 36; i++)
    begin
      op = 4'(i % 9);
      a = (op == 4'h8) ? 32'h64 : $urandom;
      b = $urandom;
      if (i / 9 == 1)
      begin
        a[7:0] = 8'h00;
        b[15:0] = 16'h0;
      end
      if (op == 4'h8)
        b = (i / 9 == 1) ? 32'h0 : (i / 9 == 2) ? 32'h5 : (i / 9 == 3) ? 32'hFFFF_FF38 : 32'hFFFF_FFF6;
      f = 8'($urandom);
      if (i / 9 == 1)
        f[0] = 1'h0;
      apb(1'h1, 8'h14, {24'h0, f});
      apb(1'h1, 8'h18, a);
      apb(1'h1, 8'h1C, b);
      apb(1'h1, 8'h20, {28'h0, op});
      apb(1'h0, 8'h14, 32'h0);
      chk("ccr", {24'h0, expCcr(op, a, b, f)}, rdv);
    end
    for (int i = 0; i < 16; i++)
    begin
      apb(1'h1, 8'h24, {16'h0, 4'h4, 4'(i), 8'($urandom)});
      apb(1'h0, 8'h28, 32'h0);
      chk("branch", {24'h0, 4'(i), 4'h1}, rdv);
    end
    for (int i = 0; i < 10; i++)
    begin
      apb(1'h1, 8'h24, {16'h0, fb[i / 2], 1'(i), 7'($urandom)});
      apb(1'h0, 8'h28, 32'h0);
      chk("pair", {28'h0, cl[i / 2] + 4'(i % 2)}, {28'h0, rdv[3:0]});
    end
    finish_test();
  end
endmodule
`default_nettype wire
